// ===== verilog/xcfs_pkg.sv
// Constants and types shared by the crosscheck fault stop sequencer
package xcfs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PULSE_DIS_TIME_US = 100;
  localparam int PULSE_DIS_CYCLES = PULSE_DIS_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ESC_DELAY = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_FAULT_CODE = 8'h08;
  localparam logic [7:0] REG_INT_STATUS = 8'h0C;
  localparam logic [7:0] REG_INT_ENABLE = 8'h10;
  localparam logic [7:0] REG_INT_CLEAR = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int WORD_MSG_BIT = 0;
  localparam int WORD_ESC_BIT = 1;
  localparam int STATE_WORD_LSB = 8;
  localparam int STATE_DRV_BRAKE_BIT = 16;
  localparam logic [31:0] ESC_DELAY_RST = 32'h0000_0000;
  localparam logic [3:0] INT_ENABLE_RST = 4'h0;
  localparam logic [7:0] FAULT_CODE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    XCFS_IDLE = 3'b000,
    XCFS_MSG = 3'b001,
    XCFS_DELAY = 3'b010,
    XCFS_BRAKE = 3'b011,
    XCFS_PULSE = 3'b100,
    XCFS_EXEMPT = 3'b101
  } xcfs_state_type;

  typedef struct packed {
    logic pulse_off;
    logic brake;
    logic escal;
    logic msg;
  } xcfs_evt_type;

endpackage

// ===== verilog/xcfs_delay_timer.sv
// Load-and-count delay timer with same-cycle expiry for a zero load
`timescale 1ns/1ps
module xcfs_delay_timer
  import xcfs_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic done
);

  logic [W-1:0] cnt_r;
  logic run_r;

  // Zero load expires at once so no cycle is lost
  assign done = start ? (load == '0) : (run_r && (cnt_r == W'(1)));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      run_r <= (load != '0);
    end else if (done) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

endmodule // xcfs_delay_timer

// ===== verilog/xcfs_sequencer.sv
// Crosscheck fault stop sequencer with APB registers and interrupt
//
// How it works
// - Only the channel crosscheck mismatch input can raise this stop response.
// - Mismatch without monitoring latches defect message on both channels; machining continues.
// - Message-only case asserts start inhibit.
// - Message-only defect cleared solely by reset key input.
// - Mismatch with monitoring active starts speed-braking stop escalating to pulse cancel.
// - Zero-speed, path-braking or retract stop already active makes it an exception.
// - Configurable delay separates fault and speed-braking stop.
// - Speed-braking applied at delay end despite other stops arriving meanwhile.
// - Bit 1 of axis and global fault words marks pending escalation.
// - Drive channel own monitoring stops act at once, no delay.
// - Without monitoring, escalation and bit setting start when monitoring activates.
// - Fault code stored for drive and shown with control alarm.
// - After speed-braking or pulse cancel, only power-on reset clears.
// - Drive-only monitoring: drive brakes alone, control status bit 1 stays clear.
// - Speed-braking becomes pulse cancel at standstill or pulse timer expiry.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module xcfs_sequencer
  import xcfs_pkg::*;
#(
  parameter int DELAY_W = 32,
  parameter int PULSE_DIS_CNT = PULSE_DIS_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic XCHECK_MISMATCH,
  input wire logic [7:0] XCHECK_CODE,
  input wire logic CTRL_MON_ACTIVE,
  input wire logic DRV_MON_ACTIVE,
  input wire logic DRV_OWN_STOP_REQ,
  input wire logic ZERO_SPEED_STOP_ACT,
  input wire logic PATH_STOP_ACT,
  input wire logic RETRACT_STOP_ACT,
  input wire logic BELOW_STANDSTILL_TOL,
  input wire logic RESET_KEY,
  output logic DEFECT_MSG_DRV,
  output logic DEFECT_MSG_CTRL,
  output logic START_INHIBIT,
  output logic SPEED_BRAKE_CTRL,
  output logic SPEED_BRAKE_DRV,
  output logic PULSE_CANCEL,
  output logic [1:0] AXIS_XCHECK_FAULT_WORD,
  output logic [1:0] GLOBAL_XCHECK_FAULT_WORD,
  output logic [7:0] DRIVE_XCHECK_FAULT_CODE,
  output logic [7:0] ALARM_CODE,
  output logic ALARM_ACTIVE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  xcfs_state_type state_r, state_nxt;
  logic [DELAY_W-1:0] esc_delay_r;
  logic [1:0] fault_word_r;
  logic [7:0] fault_code_r;
  logic drv_brake_r;
  xcfs_evt_type int_status_r, int_enable_r, evt;
  logic other_stop, esc_go, esc_done, pls_start, pls_done;
  logic wr_en, rd_en, addr_ok;
  logic [31:0] rd_data;

  function automatic logic is_escalated(input xcfs_state_type s);
    return (s == XCFS_BRAKE) || (s == XCFS_PULSE);
  endfunction

  // ----------------------------------------------------------------
  // Escalation decision
  // ----------------------------------------------------------------
  assign other_stop = ZERO_SPEED_STOP_ACT | PATH_STOP_ACT | RETRACT_STOP_ACT;
  assign esc_go = CTRL_MON_ACTIVE && !other_stop &&
                  (((state_r == XCFS_IDLE) && XCHECK_MISMATCH) || (state_r == XCFS_MSG));
  assign pls_start = (state_nxt == XCFS_BRAKE) && (state_r != XCFS_BRAKE);
  xcfs_delay_timer #(.W(DELAY_W)) u_esc_timer (
    .clk(SYS_CLK), .nrst(NRST),
    .start(esc_go), .load(esc_delay_r), .done(esc_done)
  );
  xcfs_delay_timer #(.W(32)) u_pls_timer (
    .clk(SYS_CLK), .nrst(NRST),
    .start(pls_start), .load(32'(PULSE_DIS_CNT)), .done(pls_done)
  );

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      XCFS_IDLE: begin
        if (XCHECK_MISMATCH) begin
          if (other_stop) begin
            state_nxt = XCFS_EXEMPT;
          end else if (CTRL_MON_ACTIVE) begin
            state_nxt = esc_done ? XCFS_BRAKE : XCFS_DELAY;
          end else begin
            state_nxt = XCFS_MSG;
          end
        end
      end
      XCFS_MSG: begin
        if (CTRL_MON_ACTIVE) begin
          if (other_stop) begin
            state_nxt = XCFS_EXEMPT;
          end else begin
            state_nxt = esc_done ? XCFS_BRAKE : XCFS_DELAY;
          end
        end else if (RESET_KEY) begin
          state_nxt = XCFS_IDLE;
        end
      end
      XCFS_DELAY: begin
        // other stops do not hold it off
        if (esc_done) begin
          state_nxt = XCFS_BRAKE;
        end
      end
      XCFS_BRAKE: begin
        if (BELOW_STANDSTILL_TOL || pls_done) begin
          state_nxt = XCFS_PULSE;
        end
      end
      XCFS_PULSE: state_nxt = XCFS_PULSE;
      XCFS_EXEMPT: begin
        if (RESET_KEY) begin
          state_nxt = XCFS_IDLE;
        end
      end
      default: begin
        state_nxt = XCFS_IDLE;
      end
    endcase
  end
  // escalated states leave only on reset
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state_r <= XCFS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status words and fault code
  // ----------------------------------------------------------------
  // bit 1 marks a coming speed-braking stop
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      fault_word_r <= 2'h0;
    end else begin
      fault_word_r[WORD_MSG_BIT] <= (state_nxt == XCFS_MSG);
      if (esc_go) begin
        fault_word_r[WORD_ESC_BIT] <= 1'b1;
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      fault_code_r <= FAULT_CODE_RST;
    end else if ((state_r == XCFS_IDLE) && XCHECK_MISMATCH) begin
      fault_code_r <= XCHECK_CODE;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      drv_brake_r <= 1'b0;
    end else if (DRV_OWN_STOP_REQ ||
                 ((state_r == XCFS_MSG) && DRV_MON_ACTIVE && !CTRL_MON_ACTIVE)) begin
      drv_brake_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // message latched on both channels
  assign DEFECT_MSG_DRV = (state_r != XCFS_IDLE);
  assign DEFECT_MSG_CTRL = (state_r != XCFS_IDLE);
  assign START_INHIBIT = (state_r != XCFS_IDLE) || drv_brake_r;
  // combinational so a zero delay costs no cycle
  assign SPEED_BRAKE_CTRL = (state_r == XCFS_BRAKE) ||
                            (esc_go && esc_done) || ((state_r == XCFS_DELAY) && esc_done);
  assign SPEED_BRAKE_DRV = SPEED_BRAKE_CTRL || drv_brake_r;
  assign PULSE_CANCEL = (state_r == XCFS_PULSE);
  assign AXIS_XCHECK_FAULT_WORD = fault_word_r;
  assign GLOBAL_XCHECK_FAULT_WORD = fault_word_r;
  assign DRIVE_XCHECK_FAULT_CODE = fault_code_r;
  assign ALARM_CODE = fault_code_r;
  assign ALARM_ACTIVE = (state_r != XCFS_IDLE);

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  assign evt.msg = (state_nxt == XCFS_MSG) && (state_r == XCFS_IDLE);
  assign evt.escal = esc_go;
  assign evt.brake = pls_start;
  assign evt.pulse_off = (state_nxt == XCFS_PULSE) && (state_r == XCFS_BRAKE);
  // Set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      int_status_r <= '0;
    end else if (wr_en && (PADDR == REG_INT_CLEAR)) begin
      int_status_r <= (int_status_r & ~xcfs_evt_type'(PWDATA[3:0])) | evt;
    end else begin
      int_status_r <= int_status_r | evt;
    end
  end
  assign IRQ = |(int_status_r & int_enable_r);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign addr_ok = (PADDR == REG_ESC_DELAY) || (PADDR == REG_STATE) ||
                   (PADDR == REG_FAULT_CODE) || (PADDR == REG_INT_STATUS) ||
                   (PADDR == REG_INT_ENABLE) || (PADDR == REG_INT_CLEAR);
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  // Delay is sampled at the raise; later writes affect the next one only
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      esc_delay_r <= DELAY_W'(ESC_DELAY_RST);
      int_enable_r <= INT_ENABLE_RST;
    end else if (wr_en) begin
      if (PADDR == REG_ESC_DELAY) begin
        esc_delay_r <= PWDATA[DELAY_W-1:0];
      end
      if (PADDR == REG_INT_ENABLE) begin
        int_enable_r <= PWDATA[3:0];
      end
    end
  end
  always_comb begin
    rd_data = 32'h0000_0000;
    case (PADDR)
      REG_ESC_DELAY: rd_data[DELAY_W-1:0] = esc_delay_r;
      REG_STATE: begin
        rd_data[2:0] = state_r;
        rd_data[STATE_WORD_LSB +: 2] = fault_word_r;
        rd_data[STATE_DRV_BRAKE_BIT] = drv_brake_r;
      end
      REG_FAULT_CODE: rd_data[7:0] = fault_code_r;
      REG_INT_STATUS: rd_data[3:0] = int_status_r;
      REG_INT_ENABLE: rd_data[3:0] = int_enable_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end
  // Read data captured in setup so it stands through the access phase
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      PRDATA <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_raise_only_mismatch: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_IDLE) && !XCHECK_MISMATCH |=> (state_r == XCFS_IDLE))
    else $error("state left idle without mismatch");
  a_msg_keeps_running: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_MSG) |-> DEFECT_MSG_DRV && DEFECT_MSG_CTRL && !PULSE_CANCEL)
    else $error("message case stopped machining");
  a_msg_start_inhibit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r != XCFS_IDLE) |-> START_INHIBIT)
    else $error("start not inhibited while faulted");
  a_msg_key_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_MSG) && !RESET_KEY && !CTRL_MON_ACTIVE |=> (state_r == XCFS_MSG))
    else $error("message cleared without reset key");
  a_escalate_start: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_IDLE) && XCHECK_MISMATCH && CTRL_MON_ACTIVE && !other_stop
    |=> (state_r == XCFS_DELAY) || (state_r == XCFS_BRAKE))
    else $error("no escalation with monitoring active");
  a_exempt_other: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_IDLE) && XCHECK_MISMATCH && other_stop |=> (state_r == XCFS_EXEMPT))
    else $error("exception not taken");
  a_delay_to_brake: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_DELAY) && esc_done |-> SPEED_BRAKE_CTRL ##1 (state_r == XCFS_BRAKE))
    else $error("braking missing at delay end");
  a_word_bit_one: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_DELAY) || is_escalated(state_r) |-> AXIS_XCHECK_FAULT_WORD[1]
    && GLOBAL_XCHECK_FAULT_WORD[1])
    else $error("status bit 1 clear while escalating");
  a_own_stop_now: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    DRV_OWN_STOP_REQ |=> SPEED_BRAKE_DRV)
    else $error("drive own stop delayed");
  a_late_activate: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_MSG) && CTRL_MON_ACTIVE && !other_stop
    |=> AXIS_XCHECK_FAULT_WORD[1] && (state_r != XCFS_MSG))
    else $error("late activation not escalated");
  a_code_capture: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_IDLE) && XCHECK_MISMATCH |=> DRIVE_XCHECK_FAULT_CODE ==
    $past(XCHECK_CODE) && ALARM_CODE == DRIVE_XCHECK_FAULT_CODE)
    else $error("fault code not captured");
  a_power_on_only: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    is_escalated(state_r) |=> is_escalated(state_r) && START_INHIBIT)
    else $error("escalated stop left without power on");
  a_drive_alone: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_MSG) && DRV_MON_ACTIVE && !CTRL_MON_ACTIVE
    |=> SPEED_BRAKE_DRV && !AXIS_XCHECK_FAULT_WORD[1])
    else $error("drive-alone braking wrong");
  a_pulse_change: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (state_r == XCFS_BRAKE) && BELOW_STANDSTILL_TOL |=> PULSE_CANCEL)
    else $error("no pulse cancel at standstill");
  a_zero_delay: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    esc_go && (esc_delay_r == '0) |-> SPEED_BRAKE_CTRL)
    else $error("zero delay did not brake at once");

endmodule // xcfs_sequencer

// ===== dv/xcfs_operator_model.sv
// Operator logic model that reacts to the crosscheck fault status bits
`timescale 1ns/1ps
module xcfs_operator_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] axis_word,
  input wire logic retract_en,
  input wire logic retract_force,
  output logic retract_act
);
  // ----------------------------------------------------------------
  // Retract launch
  // ----------------------------------------------------------------
  // retract on bit1 only
  // Force lets a scenario have a retract active before any fault
  always_ff @(posedge clk) begin
    if (!nrst) begin
      retract_act <= 1'b0;
    end else begin
      retract_act <= retract_force | (retract_en & axis_word[1]);
    end
  end
endmodule // xcfs_operator_model

// ===== dv/test_xcfs_sequencer.sv
// Self-checking bench for the crosscheck fault stop sequencer
`timescale 1ns/1ps
module test_xcfs_sequencer;
  import xcfs_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, code = 8'h00, drv_code, alarm_code;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, errv, mism = 1'b0, ctrl_mon = 1'b0, drv_mon = 1'b0;
  logic own_stop = 1'b0, zero_stop = 1'b0, path_stop = 1'b0, retract_stop;
  logic below_tol = 1'b0, reset_key = 1'b0, retract_en = 1'b0, retract_force = 1'b0;
  logic msg_drv, msg_ctrl, inhibit, brake_ctrl, brake_drv, pulse_cancel, alarm_act, irq;
  logic [1:0] axis_word, glob_word;
  int err_total = 0, comparisons = 0, cycles = 0, n;
  // Small pulse timer keeps the run short
  xcfs_sequencer #(.DELAY_W(32), .PULSE_DIS_CNT(5)) DUT (.SYS_CLK(sys_clk), .NRST(nrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .XCHECK_MISMATCH(mism),
    .XCHECK_CODE(code), .CTRL_MON_ACTIVE(ctrl_mon), .DRV_MON_ACTIVE(drv_mon),
    .DRV_OWN_STOP_REQ(own_stop), .ZERO_SPEED_STOP_ACT(zero_stop), .PATH_STOP_ACT(path_stop),
    .RETRACT_STOP_ACT(retract_stop), .BELOW_STANDSTILL_TOL(below_tol), .RESET_KEY(reset_key),
    .DEFECT_MSG_DRV(msg_drv), .DEFECT_MSG_CTRL(msg_ctrl), .START_INHIBIT(inhibit),
    .SPEED_BRAKE_CTRL(brake_ctrl), .SPEED_BRAKE_DRV(brake_drv), .PULSE_CANCEL(pulse_cancel),
    .AXIS_XCHECK_FAULT_WORD(axis_word), .GLOBAL_XCHECK_FAULT_WORD(glob_word),
    .DRIVE_XCHECK_FAULT_CODE(drv_code), .ALARM_CODE(alarm_code), .ALARM_ACTIVE(alarm_act),
    .IRQ(irq));
  xcfs_operator_model op (.clk(sys_clk), .nrst(nrst), .axis_word(axis_word),
    .retract_en(retract_en), .retract_force(retract_force), .retract_act(retract_stop));
  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits on pready; a stall ends only at the bench timeout
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse_mism(input logic [7:0] c);
    @(posedge sys_clk);
    mism <= 1'b1;
    code <= c;
    @(posedge sys_clk);
    mism <= 1'b0;
    #1;
  endtask
  task automatic key();
    @(posedge sys_clk);
    reset_key <= 1'b1;
    @(posedge sys_clk);
    reset_key <= 1'b0;
    settle();
  endtask
  task automatic expect_brake(input int d);
    repeat (d - 2) @(posedge sys_clk);
    #1;
    chk(brake_ctrl, 1'b0);
    settle();
    chk(brake_ctrl, 1'b1);
  endtask
  task automatic tb_reset();
    @(posedge sys_clk);
    nrst <= 1'b0;
    {ctrl_mon, drv_mon, zero_stop, path_stop, below_tol, retract_en, retract_force} <= '0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, REG_ESC_DELAY, 32'h0);
    chk(rdv, ESC_DELAY_RST);
    apb(1'b0, REG_INT_ENABLE, 32'h0);
    chk(rdv, {28'h0, INT_ENABLE_RST});
    apb(1'b0, 8'h20, 32'h0);
    chk({rdv[30:0], errv}, 32'h1);
    apb(1'b1, REG_ESC_DELAY, 32'h0000_0009);
    apb(1'b0, REG_ESC_DELAY, 32'h0);
    chk(rdv, 32'h0000_0009);
    // Other stop inputs alone raise nothing
    @(posedge sys_clk);
    {zero_stop, path_stop, below_tol, ctrl_mon} <= 4'hF;
    repeat (3) settle();
    chk({msg_ctrl, msg_drv, axis_word}, 4'h0);
    tb_reset();
    // Message-only path, interrupt and reset key
    @(posedge sys_clk);
    retract_en <= 1'b1;
    pulse_mism(8'h5A);
    chk({msg_drv, msg_ctrl, inhibit, alarm_act}, 4'hF);
    chk({brake_ctrl, brake_drv, pulse_cancel, axis_word, glob_word}, 7'h05);
    chk({drv_code, alarm_code}, 16'h5A5A);
    apb(1'b0, REG_STATE, 32'h0);
    chk(rdv & 32'h0000_0307, 32'h0000_0101);
    apb(1'b1, REG_INT_ENABLE, 32'h1);
    settle();
    chk(irq, 1'b1);
    apb(1'b1, REG_INT_ENABLE, 32'h0);
    settle();
    chk(irq, 1'b0);
    apb(1'b1, REG_INT_ENABLE, 32'h1);
    apb(1'b1, REG_INT_CLEAR, 32'h1);
    settle();
    chk(irq, 1'b0);
    chk(retract_stop, 1'b0);
    key();
    chk({msg_drv, msg_ctrl, inhibit}, 3'h0);
    // Another stop active at the raise
    for (int i = 0; i < 3; i++) begin
      tb_reset();
      @(posedge sys_clk);
      ctrl_mon <= 1'b1;
      zero_stop <= (i == 0);
      path_stop <= (i == 1);
      retract_force <= (i == 2);
      settle();
      pulse_mism(8'h11);
      settle();
      chk({msg_ctrl, axis_word[1], brake_ctrl}, 3'h4);
      key();
      chk(msg_ctrl, 1'b0);
    end
    // Late activation, delay 4, then standstill
    tb_reset();
    apb(1'b1, REG_ESC_DELAY, 32'h4);
    pulse_mism(8'h22);
    chk({axis_word[1], brake_ctrl}, 2'h0);
    @(posedge sys_clk);
    ctrl_mon <= 1'b1;
    settle();
    chk({axis_word[1], glob_word[1]}, 2'h3);
    expect_brake(4);
    key();
    chk({brake_ctrl, brake_drv, inhibit, msg_ctrl}, 4'hF);
    @(posedge sys_clk);
    below_tol <= 1'b1;
    settle();
    chk(pulse_cancel, 1'b1);
    key();
    chk({pulse_cancel, inhibit}, 2'h3);
    tb_reset();
    settle();
    chk({pulse_cancel, inhibit, axis_word}, 4'h0);
    // Delay 6 while the operator launches a retract
    apb(1'b1, REG_ESC_DELAY, 32'h6);
    @(posedge sys_clk);
    ctrl_mon <= 1'b1;
    retract_en <= 1'b1;
    pulse_mism(8'h33);
    chk(axis_word[1], 1'b1);
    expect_brake(6);
    chk(retract_stop, 1'b1);
    settle();
    chk(pulse_cancel, 1'b0);
    n = 0;
    while (pulse_cancel !== 1'b1 && n < 10) begin
      settle();
      n++;
    end
    chk(pulse_cancel, 1'b1);
    // Zero delay brakes in the raising cycle
    tb_reset();
    @(posedge sys_clk);
    ctrl_mon <= 1'b1;
    @(posedge sys_clk);
    mism <= 1'b1;
    #1;
    chk(brake_ctrl, 1'b1);
    @(posedge sys_clk);
    mism <= 1'b0;
    // Drive-only monitoring
    tb_reset();
    @(posedge sys_clk);
    drv_mon <= 1'b1;
    pulse_mism(8'h44);
    settle();
    chk({brake_drv, brake_ctrl, axis_word[1], glob_word[1]}, 4'h8);
    // Drive own stop ignores a long delay
    tb_reset();
    apb(1'b1, REG_ESC_DELAY, 32'h32);
    @(posedge sys_clk);
    own_stop <= 1'b1;
    @(posedge sys_clk);
    own_stop <= 1'b0;
    #1;
    chk(brake_drv, 1'b1);
    end_of_test();
  end
endmodule // test_xcfs_sequencer
